// *** common/shp_bus_if.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Pins between the host processor and the device.
// ==========================================================================
interface shp_bus_if;

   logic                       cs_n;
   logic                       wr_rw_n;
   logic                       rd_ds_n;
   logic                       ale;
   logic [shp_pkg::ADDR_W-1:0] sep_addr_line;
   logic [shp_pkg::DATA_W-1:0] host_data_o;
   logic                       host_data_oe;
   logic [shp_pkg::DATA_W-1:0] dev_data_o;
   logic                       dev_data_oe;
   logic [shp_pkg::DATA_W-1:0] muxed_bus_line;
   logic                       int_oe;
   logic                       int_n;
   logic                       dma_req;
   logic                       reset_in;

   // Resolved bus level; an undriven bus floats high through the pull-up.
   assign muxed_bus_line = dev_data_oe  ? dev_data_o  :
                           host_data_oe ? host_data_o : shp_pkg::BUS_PULLUP;
   // Wired open-drain interrupt line.
   assign int_n = ~int_oe;

   modport dev (
      input  cs_n,
      input  wr_rw_n,
      input  rd_ds_n,
      input  ale,
      input  sep_addr_line,
      input  muxed_bus_line,
      input  reset_in,
      output dev_data_o,
      output dev_data_oe,
      output int_oe,
      output dma_req
   );

   modport host (
      output cs_n,
      output wr_rw_n,
      output rd_ds_n,
      output ale,
      output sep_addr_line,
      output host_data_o,
      output host_data_oe,
      output reset_in,
      input  muxed_bus_line,
      input  int_n,
      input  dma_req
   );

endinterface // shp_bus_if
`default_nettype wire

// *** common/shp_pkg.sv ***
`default_nettype none
// ==========================================================================
// Shared constants of the host bus port.
// ==========================================================================
package shp_pkg;

   localparam int DATA_W = 8;
   localparam int ADDR_W = 4;

   // Pin sample vector: {reset_in, ale, cs_n, wr_rw_n, rd_ds_n, addr, data}.
   localparam int PIN_W = 17;
   localparam logic [PIN_W-1:0] PIN_IDLE = 17'h070FF;

   // Bit positions inside the pin sample vector.
   localparam int PIN_DATA_LSB = 0;
   localparam int PIN_ADDR_LSB = 8;
   localparam int PIN_RD_DS    = 12;
   localparam int PIN_WR_RW    = 13;
   localparam int PIN_CS       = 14;
   localparam int PIN_ALE      = 15;
   localparam int PIN_RESET    = 16;

   // Reset values.
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_RST = 4'h0;
   localparam logic [DATA_W-1:0] BUS_PULLUP = 8'hFF;

   // Host timing, in nanoseconds, and the cycle counts derived from them.
   localparam int CLK_PERIOD_NS = 20;
   localparam int ADDR_PHASE_NS = 120;
   localparam int STRB_PHASE_NS = 300;
   localparam int GAP_PHASE_NS  = 120;
   localparam int ADDR_PHASE_CYC = (ADDR_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STRB_PHASE_CYC = (STRB_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GAP_PHASE_CYC  = (GAP_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] CNT_RST = 5'h00;

   // Host state machine.
   typedef enum logic [2:0] {
      H_IDLE,
      H_ADDR,
      H_HOLD,
      H_STRB,
      H_DONE
   } shp_hstate_t;

endpackage
`default_nettype wire

// *** src/shp_dev.sv ***
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Access only while select is low.
// - Write strobe low means host writes data.
// - Read strobe low means device returns data.
// - Direction high reads, low writes.
// - Data strobe rising edge ends access.
// - Muxed: shared lines carry address, then data.
// - Demuxed: lines carry data only.
// - Drive data lines only for read data.
// - Latch transparent on latch enable, holds after.
// - First access samples latch enable, picks addressing.
// - Pending interrupt pulls request line low.
// - Interrupt line is open drain.
// - Reset input high holds device reset.
// - FIFO pacing by interrupt or DMA.
// - Demuxed: four address inputs select location.
module shp_dev (
   // Clock and reset
   input  wire logic                       sys_clk,
   input  wire logic                       rst,
   // Pins
   shp_bus_if.dev                          bus,
   // Strap: high selects direction-plus-data-strobe style
   input  wire logic                       cfg_ds_style,
   // Internal resource access
   output logic [shp_pkg::ADDR_W-1:0]      acc_addr,
   output logic                            rd_strobe,
   input  wire logic [shp_pkg::DATA_W-1:0] rd_data,
   output logic                            wr_strobe,
   output logic [shp_pkg::DATA_W-1:0]      wr_data,
   // Events and pacing
   input  wire logic                       irq_req,
   input  wire logic                       fifo_ready,
   input  wire logic                       cfg_dma_mode,
   // Status
   output logic                            mode_known,
   output logic                            mode_muxed,
   output logic                            dev_in_reset
);

   // ==========================================================================
   // Pin synchronisers.
   // ==========================================================================
   logic [shp_pkg::PIN_W-1:0] pins_raw;
   logic [shp_pkg::PIN_W-1:0] s1_q;
   logic [shp_pkg::PIN_W-1:0] s2_q;
   logic [shp_pkg::PIN_W-1:0] s3_q;
   logic [shp_pkg::PIN_W-1:0] pin_q;
   assign pins_raw = {bus.reset_in, bus.ale, bus.cs_n, bus.wr_rw_n, bus.rd_ds_n,
                      bus.sep_addr_line, bus.muxed_bus_line};
   // A pin change is taken only once the second and third stages agree.
   genvar gi;
   generate
      for (gi = 0; gi < shp_pkg::PIN_W; gi++)
      begin : g_sync
         always_ff @(posedge sys_clk)
         begin
            if (rst)
            begin
               s1_q[gi]  <= shp_pkg::PIN_IDLE[gi];
               s2_q[gi]  <= shp_pkg::PIN_IDLE[gi];
               s3_q[gi]  <= shp_pkg::PIN_IDLE[gi];
               pin_q[gi] <= shp_pkg::PIN_IDLE[gi];
            end
            else
            begin
               s1_q[gi] <= pins_raw[gi];
               s2_q[gi] <= s1_q[gi];
               s3_q[gi] <= s2_q[gi];
               if (s2_q[gi] == s3_q[gi])
                  pin_q[gi] <= s3_q[gi];
            end
         end
      end
   endgenerate

   // ==========================================================================
   // Decoded pin levels.
   // ==========================================================================
   logic                       dev_rst;
   logic                       ale_f;
   logic                       cs_f;
   logic                       wr_rw_f;
   logic                       rd_ds_f;
   logic [shp_pkg::ADDR_W-1:0] addr_f;
   logic [shp_pkg::DATA_W-1:0] data_f;
   assign dev_rst = rst | pin_q[shp_pkg::PIN_RESET];
   assign ale_f   = pin_q[shp_pkg::PIN_ALE];
   assign cs_f    = ~pin_q[shp_pkg::PIN_CS];
   assign wr_rw_f = pin_q[shp_pkg::PIN_WR_RW];
   assign rd_ds_f = pin_q[shp_pkg::PIN_RD_DS];
   assign addr_f  = pin_q[shp_pkg::PIN_ADDR_LSB +: shp_pkg::ADDR_W];
   assign data_f  = pin_q[shp_pkg::PIN_DATA_LSB +: shp_pkg::DATA_W];

   // ==========================================================================
   // Bus style strap, caught while reset is held.
   // ==========================================================================
   logic style_ds_q;
   always_ff @(posedge sys_clk)
   begin
      if (dev_rst)
         style_ds_q <= cfg_ds_style;
   end

   // ==========================================================================
   // Access detection.
   // ==========================================================================
   logic acc;
   logic acc_q;
   logic is_read;
   logic acc_start;
   logic acc_end;
   always_comb
   begin
      if (style_ds_q)
      begin
         acc     = cs_f & ~rd_ds_f;
         is_read = wr_rw_f;
      end
      else
      begin
         acc     = cs_f & (~rd_ds_f | ~wr_rw_f);
         is_read = ~rd_ds_f;
      end
   end
   assign acc_start = acc & ~acc_q;
   assign acc_end   = ~acc & acc_q;
   always_ff @(posedge sys_clk)
   begin
      if (dev_rst)
         acc_q <= 1'b0;
      else
         acc_q <= acc;
   end

   // ==========================================================================
   // Addressing mode, decided once at the first access.
   // ==========================================================================
   logic mode_known_q;
   logic mode_muxed_q;
   logic muxed_now;
   assign muxed_now = mode_known_q ? mode_muxed_q : ~ale_f;
   always_ff @(posedge sys_clk)
   begin
      if (dev_rst)
      begin
         mode_known_q <= 1'b0;
         mode_muxed_q <= 1'b0;
      end
      else if (acc_start && !mode_known_q)
      begin
         mode_known_q <= 1'b1;
         mode_muxed_q <= ~ale_f;
      end
   end

   // ==========================================================================
   // Address latch for multiplexed addressing.
   // ==========================================================================
   logic [shp_pkg::ADDR_W-1:0] alatch_q;
   always_ff @(posedge sys_clk)
   begin
      if (dev_rst)
         alatch_q <= shp_pkg::ADDR_RST;
      else if (ale_f)
         alatch_q <= data_f[shp_pkg::ADDR_W-1:0];
   end

   // ==========================================================================
   // Access sequencing.
   // ==========================================================================
   logic [shp_pkg::ADDR_W-1:0] acc_addr_q;
   logic                       was_write_q;
   logic                       rd_strobe_q;
   logic                       wr_strobe_q;
   logic [shp_pkg::DATA_W-1:0] wcap_q;
   logic [shp_pkg::DATA_W-1:0] wr_data_q;
   always_ff @(posedge sys_clk)
   begin
      if (dev_rst)
      begin
         acc_addr_q  <= shp_pkg::ADDR_RST;
         was_write_q <= 1'b0;
         rd_strobe_q <= 1'b0;
      end
      else
      begin
         rd_strobe_q <= acc_start & is_read;
         if (acc_start)
         begin
            acc_addr_q  <= muxed_now ? alatch_q : addr_f;
            was_write_q <= ~is_read;
         end
      end
   end
   // Write data is taken as it stands when the access ends.
   always_ff @(posedge sys_clk)
   begin
      if (dev_rst)
      begin
         wcap_q      <= shp_pkg::DATA_RST;
         wr_data_q   <= shp_pkg::DATA_RST;
         wr_strobe_q <= 1'b0;
      end
      else
      begin
         wr_strobe_q <= acc_end & was_write_q;
         if (acc & ~is_read)
            wcap_q <= data_f;
         if (acc_end & was_write_q)
            wr_data_q <= wcap_q;
      end
   end
   // ==========================================================================
   // Read data drive.
   // ==========================================================================
   logic [shp_pkg::DATA_W-1:0] dout_q;
   logic                       doe_q;
   always_ff @(posedge sys_clk)
   begin
      if (dev_rst)
      begin
         dout_q <= shp_pkg::DATA_RST;
         doe_q  <= 1'b0;
      end
      else
      begin
         if (rd_strobe_q)
            dout_q <= rd_data;
         if (!acc)
            doe_q <= 1'b0;
         else if (rd_strobe_q)
            doe_q <= 1'b1;
      end
   end
   // ==========================================================================
   // Interrupt and DMA pacing.
   // ==========================================================================
   logic int_q;
   logic dma_q;
   always_ff @(posedge sys_clk)
   begin
      if (dev_rst)
      begin
         int_q <= 1'b0;
         dma_q <= 1'b0;
      end
      else
      begin
         int_q <= irq_req | (fifo_ready & ~cfg_dma_mode);
         dma_q <= fifo_ready & cfg_dma_mode;
      end
   end
   // ==========================================================================
   // Outputs.
   // ==========================================================================
   assign bus.dev_data_o  = dout_q;
   assign bus.dev_data_oe = doe_q;
   assign bus.int_oe      = int_q;
   assign bus.dma_req     = dma_q;
   assign acc_addr        = acc_addr_q;
   assign rd_strobe       = rd_strobe_q;
   assign wr_strobe       = wr_strobe_q;
   assign wr_data         = wr_data_q;
   assign mode_known      = mode_known_q;
   assign mode_muxed      = mode_muxed_q;
   assign dev_in_reset    = dev_rst;
endmodule // shp_dev
`default_nettype wire

// *** src/shp_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module shp_host (
   // Clock and reset
   input  wire logic                       sys_clk,
   input  wire logic                       rst,
   // Pins
   shp_bus_if.host                         bus,
   // Configuration
   input  wire logic                       cfg_muxed,
   input  wire logic                       cfg_ds_style,
   input  wire logic                       dev_reset_req,
   // Command port
   input  wire logic                       cmd_valid,
   output logic                            cmd_ready,
   input  wire logic                       cmd_write,
   input  wire logic [shp_pkg::ADDR_W-1:0] cmd_addr,
   input  wire logic [shp_pkg::DATA_W-1:0] cmd_data,
   output logic                            rsp_valid,
   output logic [shp_pkg::DATA_W-1:0]      rsp_data,
   // Device events
   output logic                            irq,
   output logic                            dma_req
);

   // ==========================================================================
   // Input synchronisers: {dma_req, int_n, data}.
   // ==========================================================================
   localparam int IN_W = shp_pkg::DATA_W + 2;
   localparam logic [IN_W-1:0] IN_IDLE = 10'h1FF;

   logic [IN_W-1:0] raw;
   logic [IN_W-1:0] s1_q;
   logic [IN_W-1:0] s2_q;
   logic [IN_W-1:0] s3_q;
   logic [IN_W-1:0] in_q;

   assign raw = {bus.dma_req, bus.int_n, bus.muxed_bus_line};

   genvar gi;
   generate
      for (gi = 0; gi < IN_W; gi++)
      begin : g_sync
         always_ff @(posedge sys_clk)
         begin
            if (rst)
            begin
               s1_q[gi] <= IN_IDLE[gi];
               s2_q[gi] <= IN_IDLE[gi];
               s3_q[gi] <= IN_IDLE[gi];
               in_q[gi] <= IN_IDLE[gi];
            end
            else
            begin
               s1_q[gi] <= raw[gi];
               s2_q[gi] <= s1_q[gi];
               s3_q[gi] <= s2_q[gi];
               if (s2_q[gi] == s3_q[gi])
               begin
                  in_q[gi] <= s3_q[gi];
               end
            end
         end
      end
   endgenerate

   // ==========================================================================
   // Access sequencer.
   // ==========================================================================
   shp_pkg::shp_hstate_t       st_q;
   logic [shp_pkg::CNT_W-1:0]  cnt_q;
   logic                       wr_q;
   logic [shp_pkg::ADDR_W-1:0] addr_q;
   logic [shp_pkg::DATA_W-1:0] data_q;
   logic                       rsp_valid_q;
   logic [shp_pkg::DATA_W-1:0] rsp_data_q;
   logic                       reset_q;
   logic                       cnt_done;

   assign cnt_done  = (cnt_q == shp_pkg::CNT_RST);
   assign cmd_ready = (st_q == shp_pkg::H_IDLE) & ~reset_q;

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         reset_q <= 1'b1;
      end
      else
      begin
         reset_q <= dev_reset_req;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         st_q        <= shp_pkg::H_IDLE;
         cnt_q       <= shp_pkg::CNT_RST;
         wr_q        <= 1'b0;
         addr_q      <= shp_pkg::ADDR_RST;
         data_q      <= shp_pkg::DATA_RST;
         rsp_valid_q <= 1'b0;
         rsp_data_q  <= shp_pkg::DATA_RST;
      end
      else
      begin
         rsp_valid_q <= 1'b0;
         if (!cnt_done)
         begin
            cnt_q <= cnt_q - 1'b1;
         end
         case (st_q)
            shp_pkg::H_IDLE:
            begin
               if (cmd_valid && cmd_ready)
               begin
                  wr_q   <= cmd_write;
                  addr_q <= cmd_addr;
                  data_q <= cmd_data;
                  if (cfg_muxed)
                  begin
                     st_q  <= shp_pkg::H_ADDR;
                     cnt_q <= shp_pkg::CNT_W'(shp_pkg::ADDR_PHASE_CYC - 1);
                  end
                  else
                  begin
                     st_q  <= shp_pkg::H_STRB;
                     cnt_q <= shp_pkg::CNT_W'(shp_pkg::STRB_PHASE_CYC - 1);
                  end
               end
            end
            shp_pkg::H_ADDR:
            begin
               if (cnt_done)
               begin
                  st_q  <= shp_pkg::H_HOLD;
                  cnt_q <= shp_pkg::CNT_W'(shp_pkg::ADDR_PHASE_CYC - 1);
               end
            end
            shp_pkg::H_HOLD:
            begin
               if (cnt_done)
               begin
                  st_q  <= shp_pkg::H_STRB;
                  cnt_q <= shp_pkg::CNT_W'(shp_pkg::STRB_PHASE_CYC - 1);
               end
            end
            shp_pkg::H_STRB:
            begin
               if (cnt_done)
               begin
                  st_q  <= shp_pkg::H_DONE;
                  cnt_q <= shp_pkg::CNT_W'(shp_pkg::GAP_PHASE_CYC - 1);
                  if (!wr_q)
                  begin
                     rsp_valid_q <= 1'b1;
                     rsp_data_q  <= in_q[shp_pkg::DATA_W-1:0];
                  end
               end
            end
            shp_pkg::H_DONE:
            begin
               if (cnt_done)
               begin
                  st_q <= shp_pkg::H_IDLE;
               end
            end
            default:
            begin
               st_q <= shp_pkg::H_IDLE;
            end
         endcase
      end
   end

   // ==========================================================================
   // Pin drive.
   // ==========================================================================
   logic strb;

   assign strb              = (st_q == shp_pkg::H_STRB);
   assign bus.cs_n          = ~strb;
   assign bus.rd_ds_n       = ~(strb & (cfg_ds_style | ~wr_q));
   assign bus.wr_rw_n       = ~(strb & wr_q);
   assign bus.ale           = cfg_muxed ? (st_q == shp_pkg::H_ADDR) : 1'b1;
   assign bus.sep_addr_line = addr_q;
   assign bus.host_data_o   = (st_q == shp_pkg::H_ADDR || st_q == shp_pkg::H_HOLD) ?
                              {{(shp_pkg::DATA_W-shp_pkg::ADDR_W){1'b0}}, addr_q} : data_q;
   assign bus.host_data_oe  = (cfg_muxed && (st_q == shp_pkg::H_ADDR ||
                                             st_q == shp_pkg::H_HOLD)) ||
                              (wr_q && (strb || st_q == shp_pkg::H_DONE));
   assign bus.reset_in      = reset_q;
   assign rsp_valid         = rsp_valid_q;
   assign rsp_data          = rsp_data_q;
   assign irq               = ~in_q[shp_pkg::DATA_W];
   assign dma_req           = in_q[shp_pkg::DATA_W+1];

endmodule // shp_host
`default_nettype wire

// *** verif/shp_port_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Pin checks between host and device.
// ==========================================================================
module shp_port_sva (
   // Clock and reset
   input wire logic                       sys_clk,
   input wire logic                       rst,
   // Pins
   input wire logic                       cs_n,
   input wire logic                       wr_rw_n,
   input wire logic                       rd_ds_n,
   input wire logic                       host_data_oe,
   input wire logic                       dev_data_oe,
   input wire logic [shp_pkg::DATA_W-1:0] dev_data_o,
   input wire logic                       int_oe,
   input wire logic                       dma_req,
   input wire logic                       reset_in
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence rd_acc_s;
      !cs_n && !rd_ds_n && wr_rw_n;
   endsequence
   sequence wr_acc_s;
      !cs_n && !wr_rw_n;
   endsequence

   oe_start_a: assert property ($rose(dev_data_oe) |-> rd_acc_s)
      else $error("device drove the bus outside a read");
   rd_answer_a: assert property (rd_acc_s [*8] |=> dev_data_oe)
      else $error("read access got no data on the bus");
   rd_hold_a: assert property (dev_data_oe && $past(dev_data_oe) |-> $stable(dev_data_o))
      else $error("read data changed while driven");
   oe_release_a: assert property ($rose(cs_n) |-> ##[1:8] !dev_data_oe)
      else $error("device kept driving after the access");
   no_wr_drive_a: assert property (wr_acc_s |-> !dev_data_oe)
      else $error("device drove the bus during a write");
   no_fight_a: assert property (!(dev_data_oe && host_data_oe))
      else $error("both ends drive the bus");
   strobe_sel_a: assert property (!rd_ds_n |-> !cs_n)
      else $error("strobe low without select");
   rst_quiet_a: assert property (reset_in [*6] |-> !dev_data_oe && !int_oe && !dma_req)
      else $error("device active while reset input held");
endmodule // shp_port_sva
`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic       sys_clk = 1'b0, rst = 1'b1, ds_style = 1'b0, muxed = 1'b0;
   logic       dev_reset_req = 1'b0, irq_req = 1'b0, fifo_ready = 1'b0, dma_mode = 1'b0;
   logic       cmd_valid = 1'b0, cmd_write = 1'b0, cmd_ready, rsp_valid, h_irq, h_dma;
   logic [3:0] cmd_addr = 4'h0, acc_addr;
   logic [7:0] cmd_data = 8'h00, rsp_data, rd_data, wr_data;
   logic       rd_strobe, wr_strobe, mode_known, mode_muxed, dev_in_reset;
   int         err_count = 0, check_count = 0, cyc_count = 0;

   always #10 sys_clk = ~sys_clk;
   assign rd_data = {~acc_addr, acc_addr};

   shp_bus_if bus_if ();
   shp_dev shp_dev_inst (.sys_clk(sys_clk), .rst(rst), .bus(bus_if.dev), .cfg_ds_style(ds_style),
      .acc_addr(acc_addr), .rd_strobe(rd_strobe), .rd_data(rd_data), .wr_strobe(wr_strobe),
      .wr_data(wr_data), .irq_req(irq_req), .fifo_ready(fifo_ready), .cfg_dma_mode(dma_mode),
      .mode_known(mode_known), .mode_muxed(mode_muxed), .dev_in_reset(dev_in_reset));
   shp_host shp_host_inst (.sys_clk(sys_clk), .rst(rst), .bus(bus_if.host), .cfg_muxed(muxed),
      .cfg_ds_style(ds_style), .dev_reset_req(dev_reset_req), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .irq(h_irq), .dma_req(h_dma));
   shp_port_sva shp_port_sva_inst (.sys_clk(sys_clk), .rst(rst), .cs_n(bus_if.cs_n),
      .wr_rw_n(bus_if.wr_rw_n), .rd_ds_n(bus_if.rd_ds_n), .host_data_oe(bus_if.host_data_oe),
      .dev_data_oe(bus_if.dev_data_oe), .dev_data_o(bus_if.dev_data_o), .int_oe(bus_if.int_oe),
      .dma_req(bus_if.dma_req), .reset_in(bus_if.reset_in));

   task automatic check(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'b1)
      begin
         err_count++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask

   task automatic test_done();
      if (err_count == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic do_reset(input logic ds, input logic mux);
      rst <= 1'b1;
      ds_style <= ds;
      muxed <= mux;
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (12) @(posedge sys_clk);
   endtask

   // Issues one host command and judges its completion.
   task automatic do_cmd(input logic wr, input logic [3:0] a, input logic [7:0] d);
      int n;
      int n_rd;
      n_rd = 0;
      @(posedge sys_clk);
      cmd_write <= wr;
      cmd_addr <= a;
      cmd_data <= d;
      cmd_valid <= 1'b1;
      do
         @(posedge sys_clk);
      while (cmd_ready !== 1'b1);
      cmd_valid <= 1'b0;
      for (n = 0; n < 100; n++)
      begin
         @(posedge sys_clk);
         #1;
         if (rd_strobe === 1'b1)
            n_rd++;
         if ((wr ? wr_strobe : rsp_valid) === 1'b1)
            break;
      end
      check(n < 100, "access never completed");
      check(n_rd == (wr ? 0 : 1), "read strobe count wrong");
      if (wr)
         check(acc_addr === a && wr_data === d, "write address or data wrong");
      else
         check(rsp_data === {~a, a}, "read data wrong");
      repeat (10) @(posedge sys_clk);
   endtask

   task automatic t_style(input logic ds, input logic mux);
      do_reset(ds, mux);
      check(mode_known === 1'b0, "mode known before first access");
      do_cmd(1'b1, 4'hF, 8'hA5);
      check(mode_known === 1'b1 && mode_muxed === mux, "addressing mode wrong");
      do_cmd(1'b0, 4'h0, 8'h00);
      do_cmd(1'b0, 4'hF, 8'h00);
      do_cmd(1'b1, 4'h0, 8'h5A);
      check(mode_muxed === mux, "addressing mode not kept");
   endtask

   task automatic t_irq();
      for (int i = 0; i < 8; i++)
      begin
         @(posedge sys_clk);
         {irq_req, fifo_ready, dma_mode} <= i[2:0];
         repeat (8) @(posedge sys_clk);
         #1;
         check(h_irq === (i[2] | (i[1] & ~i[0])), "interrupt level wrong");
         check(bus_if.int_n === ~(i[2] | (i[1] & ~i[0])), "interrupt line level wrong");
         check(h_dma === (i[1] & i[0]), "dma request wrong");
      end
   endtask

   task automatic t_res_in();
      @(posedge sys_clk);
      irq_req <= 1'b1;
      dev_reset_req <= 1'b1;
      repeat (12) @(posedge sys_clk);
      #1;
      check(dev_in_reset === 1'b1 && mode_known === 1'b0, "reset input ignored");
      check(bus_if.int_n === 1'b1, "interrupt active in reset");
      @(posedge sys_clk);
      dev_reset_req <= 1'b0;
      irq_req <= 1'b0;
      repeat (12) @(posedge sys_clk);
      #1;
      check(dev_in_reset === 1'b0, "device stuck in reset");
      do_cmd(1'b0, 4'h7, 8'h00);
      check(mode_muxed === muxed, "mode lost after reset");
   endtask

   always @(posedge sys_clk)
   begin
      cyc_count <= cyc_count + 1;
      if (cyc_count == 6000)
      begin
         err_count++;
         $display("unexpected at %0t: run timed out", $time);
         test_done();
      end
   end

   initial
   begin
      t_style(1'b0, 1'b0);
      t_style(1'b0, 1'b1);
      t_style(1'b1, 1'b0);
      t_style(1'b1, 1'b1);
      t_irq();
      t_res_in();
      test_done();
   end
endmodule // tb
`default_nettype wire
